// ---- verilog/rvdvs_pkg.sv ----
/*
  shared constants of the regulator voltage and scaling register bank:
  register indices, field positions, writable masks, reset values,
  step-interval timing and the bus-side state encoding.
  assumes a 40 mhz mclk and word-aligned avalon-mm byte addressing.
*/
`default_nettype none
package rvdvs_pkg;
  // register count and index of each register (byte address = 4 x index)
  localparam int unsigned RVDVS_NREG = 5;
  localparam logic [5:0] RVDVS_IDX_CH23 = 6'h0d;
  localparam logic [5:0] RVDVS_IDX_CH45 = 6'h0e;
  localparam logic [5:0] RVDVS_IDX_CH6 = 6'h0f;
  localparam logic [5:0] RVDVS_IDX_CH7KA = 6'h10;
  localparam logic [5:0] RVDVS_IDX_SCALE = 6'h11;
  // field positions
  localparam int unsigned RVDVS_CH3_LSB = 4;
  localparam int unsigned RVDVS_CH2_LSB = 0;
  localparam int unsigned RVDVS_CH5_LSB = 4;
  localparam int unsigned RVDVS_CH4_LSB = 0;
  localparam int unsigned RVDVS_CH6_LSB = 0;
  localparam int unsigned RVDVS_KB_LSB = 5;
  localparam int unsigned RVDVS_KA_BIT = 4;
  localparam int unsigned RVDVS_CH7_LSB = 0;
  localparam int unsigned RVDVS_INT2_BIT = 5;
  localparam int unsigned RVDVS_INT1_BIT = 4;
  localparam int unsigned RVDVS_EN2_BIT = 1;
  localparam int unsigned RVDVS_EN1_BIT = 0;
  // writable bits per register, slot 4 (scaling) in the top byte
  localparam logic [39:0] RVDVS_MASKS = 40'h33_73_0f_77_7f;
  // codes that put a channel into adjustable mode
  localparam logic [2:0] RVDVS_CH3_ADJ = 3'h7;
  localparam logic [2:0] RVDVS_CH4_ADJ = 3'h7;
  localparam logic [3:0] RVDVS_CH6_ADJ = 4'hf;
  // reset values: voltages until fuses load, scaling fixed
  localparam logic [7:0] RVDVS_RST_VOLT = 8'h00;
  localparam logic [7:0] RVDVS_RST_SCALE = 8'h00;
  // fuse image: one byte per voltage register, 0x0d in the low byte
  localparam int unsigned RVDVS_FUSE_W = 32;
  // step-interval timing
  localparam int unsigned RVDVS_CLK_MHZ = 40;
  localparam int unsigned RVDVS_INT1_SHORT_US = 16;
  localparam int unsigned RVDVS_INT1_LONG_US = 32;
  localparam int unsigned RVDVS_INT2_SHORT_US = 32;
  localparam int unsigned RVDVS_INT2_LONG_US = 64;
  localparam logic [11:0] RVDVS_INT1_SHORT_CYC =
    12'(RVDVS_INT1_SHORT_US * RVDVS_CLK_MHZ);
  localparam logic [11:0] RVDVS_INT1_LONG_CYC =
    12'(RVDVS_INT1_LONG_US * RVDVS_CLK_MHZ);
  localparam logic [11:0] RVDVS_INT2_SHORT_CYC =
    12'(RVDVS_INT2_SHORT_US * RVDVS_CLK_MHZ);
  localparam logic [11:0] RVDVS_INT2_LONG_CYC =
    12'(RVDVS_INT2_LONG_US * RVDVS_CLK_MHZ);
  // bus-side states
  typedef enum logic [1:0] {
    RVDVS_LOAD = 2'b00,
    RVDVS_IDLE = 2'b01,
    RVDVS_ANSWER = 2'b10
  } rvdvs_bus_e;
endpackage
`default_nettype wire

// ---- verilog/rvdvs_fuse_load.sv ----
/*
  fuse capture: brings the factory fuse levels in through three flops
  and hands one settled image to the register bank after reset.
  assumes fuse levels are static once the device is out of reset.
*/
`default_nettype none
module rvdvs_fuse_load #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fuse pins
  input wire logic [W-1:0] fuse_bits,
  // settled image
  output logic load_ff,
  output logic [W-1:0] value_ff
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [1:0] fill_ff;
  logic done_ff;
  logic [1:0] nxt_fill;
  logic nxt_done;
  logic nxt_load;
  logic [W-1:0] nxt_value;

  // wait for the chain to fill, then take the first agreeing image
  always_comb begin
    nxt_fill = fill_ff;
    nxt_done = done_ff;
    nxt_load = 1'b0;
    nxt_value = value_ff;
    if (fill_ff != 2'h3) begin
      nxt_fill = fill_ff + 2'h1;
    end else if (!done_ff && s2_ff == s3_ff) begin
      nxt_done = 1'b1;
      nxt_load = 1'b1;
      nxt_value = s3_ff;
    end
  end

  // three-stage synchroniser and capture state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      fill_ff <= 2'h0;
      done_ff <= 1'b0;
      load_ff <= 1'b0;
      value_ff <= '0;
    end else begin
      s1_ff <= fuse_bits;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      fill_ff <= nxt_fill;
      done_ff <= nxt_done;
      load_ff <= nxt_load;
      value_ff <= nxt_value;
    end
  end

  property p_load_once;
    @(posedge mclk) disable iff (!rst_n)
    load_ff |=> !load_ff [*3];
  endproperty
  a_load_once: assert property (p_load_once)
    else $error("fuse image loaded more than once");

  property p_load_settled;
    @(posedge mclk) disable iff (!rst_n)
    $rose(load_ff) |-> value_ff == $past(s3_ff) && $past(s2_ff == s3_ff);
  endproperty
  a_load_settled: assert property (p_load_settled)
    else $error("fuse image taken before it settled");
endmodule // rvdvs_fuse_load
`default_nettype wire

// ---- verilog/rvdvs_regs.sv ----
/*
  regulator voltage-select and scaling-control register bank.
  five byte registers behind an avalon-mm slave with waitrequest;
  voltage registers start from the fuse image, scaling from zero.
  assumes a 40 mhz mclk and a master that holds its request until it
  samples waitrequest low.
*/
// Local design decision: the Avalon-MM register port.
`default_nettype none
module rvdvs_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // factory fuse image
  input wire logic [rvdvs_pkg::RVDVS_FUSE_W-1:0] fuse_bits,
  // regulator setpoints
  output logic [2:0] ch3_voltage_code,
  output logic [3:0] ch2_voltage_code,
  output logic [2:0] ch5_voltage_code,
  output logic [2:0] ch4_voltage_code,
  output logic [3:0] ch6_voltage_code,
  output logic [1:0] keepalive_b_voltage_code,
  output logic keepalive_a_voltage_code,
  output logic [1:0] ch7_voltage_code,
  // adjustable-mode flags
  output logic ch3_adjustable,
  output logic ch4_adjustable,
  output logic ch6_adjustable,
  // scaling control
  output logic ch1_scaling_enable,
  output logic ch2_scaling_enable,
  output logic ch1_scaling_step_interval,
  output logic ch2_scaling_step_interval,
  output logic [11:0] ch1_step_cycles,
  output logic [11:0] ch2_step_cycles,
  // status
  output logic fuses_loaded
);
  import rvdvs_pkg::*;

  rvdvs_bus_e state_ff;
  rvdvs_bus_e nxt_state;
  logic wait_ff;
  logic nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] regs_ff [RVDVS_NREG];
  logic [7:0] nxt_regs [RVDVS_NREG];
  logic [2:0] adj_ff;
  logic [2:0] nxt_adj;
  logic [11:0] step1_ff;
  logic [11:0] step2_ff;
  logic [11:0] nxt_step1;
  logic [11:0] nxt_step2;
  logic loaded_ff;
  logic nxt_loaded;
  logic fuse_load;
  logic [RVDVS_FUSE_W-1:0] fuse_val;
  logic [5:0] idx;
  logic hit;
  logic [2:0] slot;
  logic [7:0] slot_mask;
  logic wr_ok;

  rvdvs_fuse_load #(
    .W(RVDVS_FUSE_W)
  ) u_fuse (
    .mclk(mclk),
    .rst_n(rst_n),
    .fuse_bits(fuse_bits),
    .load_ff(fuse_load),
    .value_ff(fuse_val)
  );

  // address decode: word index, low two address bits ignored
  assign idx = avs_address[7:2];
  assign hit = idx >= RVDVS_IDX_CH23 && idx <= RVDVS_IDX_SCALE;
  assign slot = 3'(idx - RVDVS_IDX_CH23);
  assign slot_mask = hit ? RVDVS_MASKS[{slot, 3'b000} +: 8] : 8'h00;
  assign wr_ok = avs_write && avs_byteenable[0] && hit;

  // bus handshake, fuse load and register updates
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    nxt_loaded = loaded_ff;
    for (int i = 0; i < RVDVS_NREG; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    case (state_ff)
      RVDVS_LOAD: begin
        if (fuse_load) begin
          for (int i = 0; i < RVDVS_NREG - 1; i++) begin
            nxt_regs[i] = fuse_val[8*i +: 8] &
              RVDVS_MASKS[8*i +: 8];
          end
          nxt_loaded = 1'b1;
          nxt_state = RVDVS_IDLE;
        end
      end
      RVDVS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_state = RVDVS_ANSWER;
          nxt_wait = 1'b0;
          nxt_rdata = hit ? {24'h000000, regs_ff[slot]} :
            32'h00000000;
        end
      end
      RVDVS_ANSWER: begin
        nxt_state = RVDVS_IDLE;
        if (wr_ok) begin
          nxt_regs[slot] = avs_writedata[7:0] & slot_mask;
        end
      end
      default: begin
        nxt_state = RVDVS_LOAD;
      end
    endcase
  end

  // derived flags and step lengths follow the next register values
  always_comb begin
    nxt_adj[0] = nxt_regs[0][RVDVS_CH3_LSB +: 3] == RVDVS_CH3_ADJ;
    nxt_adj[1] = nxt_regs[1][RVDVS_CH4_LSB +: 3] == RVDVS_CH4_ADJ;
    nxt_adj[2] = nxt_regs[2][RVDVS_CH6_LSB +: 4] == RVDVS_CH6_ADJ;
    nxt_step1 = nxt_regs[4][RVDVS_INT1_BIT] ?
      RVDVS_INT1_LONG_CYC : RVDVS_INT1_SHORT_CYC;
    nxt_step2 = nxt_regs[4][RVDVS_INT2_BIT] ?
      RVDVS_INT2_LONG_CYC : RVDVS_INT2_SHORT_CYC;
  end

  // state registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= RVDVS_LOAD;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
      loaded_ff <= 1'b0;
      for (int i = 0; i < RVDVS_NREG - 1; i++) begin
        regs_ff[i] <= RVDVS_RST_VOLT;
      end
      regs_ff[RVDVS_NREG-1] <= RVDVS_RST_SCALE;
      adj_ff <= 3'h0;
      step1_ff <= RVDVS_INT1_SHORT_CYC;
      step2_ff <= RVDVS_INT2_SHORT_CYC;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      loaded_ff <= nxt_loaded;
      for (int i = 0; i < RVDVS_NREG; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
      adj_ff <= nxt_adj;
      step1_ff <= nxt_step1;
      step2_ff <= nxt_step2;
    end
  end

  // outputs are slices of the registers
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign ch3_voltage_code = regs_ff[0][RVDVS_CH3_LSB +: 3];
  assign ch2_voltage_code = regs_ff[0][RVDVS_CH2_LSB +: 4];
  assign ch5_voltage_code = regs_ff[1][RVDVS_CH5_LSB +: 3];
  assign ch4_voltage_code = regs_ff[1][RVDVS_CH4_LSB +: 3];
  assign ch6_voltage_code = regs_ff[2][RVDVS_CH6_LSB +: 4];
  assign keepalive_b_voltage_code = regs_ff[3][RVDVS_KB_LSB +: 2];
  assign keepalive_a_voltage_code = regs_ff[3][RVDVS_KA_BIT];
  assign ch7_voltage_code = regs_ff[3][RVDVS_CH7_LSB +: 2];
  assign ch3_adjustable = adj_ff[0];
  assign ch4_adjustable = adj_ff[1];
  assign ch6_adjustable = adj_ff[2];
  assign ch1_scaling_enable = regs_ff[4][RVDVS_EN1_BIT];
  assign ch2_scaling_enable = regs_ff[4][RVDVS_EN2_BIT];
  assign ch1_scaling_step_interval = regs_ff[4][RVDVS_INT1_BIT];
  assign ch2_scaling_step_interval = regs_ff[4][RVDVS_INT2_BIT];
  assign ch1_step_cycles = step1_ff;
  assign ch2_step_cycles = step2_ff;
  assign fuses_loaded = loaded_ff;

  property p_ch23_write;
    @(posedge mclk) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address[7:2] == 6'h0d
    |=> ch3_voltage_code == $past(avs_writedata[6:4]) &&
      ch2_voltage_code == $past(avs_writedata[3:0]);
  endproperty
  a_ch23_write: assert property (p_ch23_write)
    else $error("ch2/ch3 setpoint did not follow write");

  property p_ch3_adjust;
    @(posedge mclk) disable iff (!rst_n)
    ch3_adjustable == (ch3_voltage_code == 3'h7);
  endproperty
  a_ch3_adjust: assert property (p_ch3_adjust)
    else $error("ch3 adjustable flag wrong");

  property p_ch45_write;
    @(posedge mclk) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address[7:2] == 6'h0e
    |=> ch5_voltage_code == $past(avs_writedata[6:4]);
  endproperty
  a_ch45_write: assert property (p_ch45_write)
    else $error("ch5 setpoint did not follow write");

  property p_ch4_adjust;
    @(posedge mclk) disable iff (!rst_n)
    ch4_adjustable == (ch4_voltage_code == 3'h7) &&
      ch6_adjustable == (ch6_voltage_code == 4'hf);
  endproperty
  a_ch4_adjust: assert property (p_ch4_adjust)
    else $error("ch4/ch6 adjustable flag wrong");

  property p_ch6_write;
    @(posedge mclk) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address[7:2] == 6'h0f
    |=> ch6_voltage_code == $past(avs_writedata[3:0]) ##1
      $stable(ch6_voltage_code);
  endproperty
  a_ch6_write: assert property (p_ch6_write)
    else $error("ch6 setpoint did not follow write");

  property p_ch7ka_write;
    @(posedge mclk) disable iff (!rst_n)
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address[7:2] == 6'h10
    |=> keepalive_b_voltage_code == $past(avs_writedata[6:5]) &&
      keepalive_a_voltage_code == $past(avs_writedata[4]) &&
      ch7_voltage_code == $past(avs_writedata[1:0]);
  endproperty
  a_ch7ka_write: assert property (p_ch7ka_write)
    else $error("ch7/keep-alive setpoint did not follow write");

  property p_fuse_load;
    @(posedge mclk) disable iff (!rst_n)
    $rose(fuses_loaded) |-> ch2_voltage_code == fuse_val[3:0] &&
      ch4_voltage_code == fuse_val[10:8] &&
      ch7_voltage_code == fuse_val[25:24];
  endproperty
  a_fuse_load: assert property (p_fuse_load)
    else $error("setpoints not taken from fuse image");

  property p_step2;
    @(posedge mclk) disable iff (!rst_n)
    ch2_step_cycles == (ch2_scaling_step_interval ?
      RVDVS_INT2_LONG_CYC : RVDVS_INT2_SHORT_CYC);
  endproperty
  a_step2: assert property (p_step2)
    else $error("ch2 step length does not match interval bit");

  property p_step1;
    @(posedge mclk) disable iff (!rst_n)
    ch1_step_cycles == (ch1_scaling_step_interval ?
      RVDVS_INT1_LONG_CYC : RVDVS_INT1_SHORT_CYC);
  endproperty
  a_step1: assert property (p_step1)
    else $error("ch1 step length does not match interval bit");

  property p_scale_idle;
    @(posedge mclk) disable iff (!rst_n)
    !fuses_loaded |-> !ch2_scaling_enable && !ch1_scaling_enable;
  endproperty
  a_scale_idle: assert property (p_scale_idle)
    else $error("scaling enabled straight out of reset");

  property p_reserved;
    @(posedge mclk) disable iff (!rst_n)
    avs_read && !avs_waitrequest |->
      avs_readdata[31:8] == 24'h000000 &&
      (avs_readdata[7:0] & ~slot_mask) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read back nonzero");

  property p_answer;
    @(posedge mclk) disable iff (!rst_n)
    fuses_loaded && avs_waitrequest && (avs_read || avs_write)
    |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered in one cycle");
endmodule // rvdvs_regs
`default_nettype wire

// ---- testbench/tb.sv ----
/*
  self-checking bench for the regulator voltage and scaling registers:
  fuse defaults, field-to-setpoint mapping, masked bits, unmapped words,
  byte-enable refusal and a second reset.
  assumes the register bank's avalon-mm slave and a static fuse image.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // clock and reset
  logic mclk;
  logic rst_n;
  // bus side
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // fuse image and setpoints
  logic [31:0] fuse_bits;
  logic [2:0] ch3_voltage_code;
  logic [3:0] ch2_voltage_code;
  logic [2:0] ch5_voltage_code;
  logic [2:0] ch4_voltage_code;
  logic [3:0] ch6_voltage_code;
  logic [1:0] keepalive_b_voltage_code;
  logic keepalive_a_voltage_code;
  logic [1:0] ch7_voltage_code;
  logic ch3_adjustable;
  logic ch4_adjustable;
  logic ch6_adjustable;
  logic ch1_scaling_enable;
  logic ch2_scaling_enable;
  logic ch1_scaling_step_interval;
  logic ch2_scaling_step_interval;
  logic [11:0] ch1_step_cycles;
  logic [11:0] ch2_step_cycles;
  logic fuses_loaded;

  int n_errors = 0;
  int checked = 0;
  logic [7:0] exp_reg [5];

  rvdvs_regs DUT (
    .mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fuse_bits(fuse_bits),
    .ch3_voltage_code(ch3_voltage_code),
    .ch2_voltage_code(ch2_voltage_code),
    .ch5_voltage_code(ch5_voltage_code),
    .ch4_voltage_code(ch4_voltage_code),
    .ch6_voltage_code(ch6_voltage_code),
    .keepalive_b_voltage_code(keepalive_b_voltage_code),
    .keepalive_a_voltage_code(keepalive_a_voltage_code),
    .ch7_voltage_code(ch7_voltage_code),
    .ch3_adjustable(ch3_adjustable), .ch4_adjustable(ch4_adjustable),
    .ch6_adjustable(ch6_adjustable),
    .ch1_scaling_enable(ch1_scaling_enable),
    .ch2_scaling_enable(ch2_scaling_enable),
    .ch1_scaling_step_interval(ch1_scaling_step_interval),
    .ch2_scaling_step_interval(ch2_scaling_step_interval),
    .ch1_step_cycles(ch1_step_cycles), .ch2_step_cycles(ch2_step_cycles),
    .fuses_loaded(fuses_loaded)
  );

  // 40 mhz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // writable bits of each register slot
  function automatic logic [7:0] wmask(input int i);
    case (i)
      0: return 8'h7f;
      1: return 8'h77;
      2: return 8'h0f;
      3: return 8'h73;
      default: return 8'h33;
    endcase
  endfunction

  // byte address of slot i, word index 0x0d upwards
  function automatic logic [7:0] addr_of(input int i);
    return 8'((13 + i) * 4);
  endfunction

  task automatic wrap_up();
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value read t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value pin t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one bus cycle; holds the request until waitrequest is sampled low
  task automatic bus_cycle(input logic wr, input logic [7:0] a,
                           input logic [31:0] d, input logic [3:0] be,
                           output logic [31:0] rd);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 100) begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic read_all();
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      bus_cycle(1'b0, addr_of(i), 32'h0, 4'h0, d);
      chk_rd(d, {24'h0, exp_reg[i]});
    end
  endtask

  // setpoints against the expected register image
  task automatic chk_outs();
    @(posedge mclk);
    chk_pin(32'(ch3_voltage_code), 32'(exp_reg[0][6:4]));
    chk_pin(32'(ch3_adjustable), 32'(exp_reg[0][6:4] == 3'h7));
    chk_pin(32'(ch2_voltage_code), 32'(exp_reg[0][3:0]));
    chk_pin(32'(ch5_voltage_code), 32'(exp_reg[1][6:4]));
    chk_pin(32'(ch4_voltage_code), 32'(exp_reg[1][2:0]));
    chk_pin(32'(ch4_adjustable), 32'(exp_reg[1][2:0] == 3'h7));
    chk_pin(32'(ch6_voltage_code), 32'(exp_reg[2][3:0]));
    chk_pin(32'(ch6_adjustable), 32'(exp_reg[2][3:0] == 4'hf));
    chk_pin(32'(keepalive_b_voltage_code), 32'(exp_reg[3][6:5]));
    chk_pin(32'(keepalive_a_voltage_code), 32'(exp_reg[3][4]));
    chk_pin(32'(ch7_voltage_code), 32'(exp_reg[3][1:0]));
    chk_pin(32'(ch2_scaling_step_interval), 32'(exp_reg[4][5]));
    chk_pin(32'(ch2_step_cycles), exp_reg[4][5] ? 32'd2560 : 32'd1280);
    chk_pin(32'(ch1_scaling_step_interval), 32'(exp_reg[4][4]));
    chk_pin(32'(ch1_step_cycles), exp_reg[4][4] ? 32'd1280 : 32'd640);
    chk_pin(32'(ch2_scaling_enable), 32'(exp_reg[4][1]));
    chk_pin(32'(ch1_scaling_enable), 32'(exp_reg[4][0]));
    chk_pin(32'(fuses_loaded), 32'h1);
  endtask

  // release reset, wait for the fuse image, rebuild expectations
  task automatic start_up();
    int n;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (fuses_loaded === 1'b1) break;
    end
    if (n == 50) begin
      n_errors++;
      wrap_up();
    end
    for (int i = 0; i < 4; i++) exp_reg[i] = fuse_bits[8*i +: 8] & wmask(i);
    exp_reg[4] = 8'h00;
    chk_outs();
    read_all();
  endtask

  task automatic wr_reg(input int i, input logic [31:0] d,
                        input logic [3:0] be);
    logic [31:0] rd;
    bus_cycle(1'b1, addr_of(i), d, be, rd);
    if (be[0]) exp_reg[i] = d[7:0] & wmask(i);
  endtask

  // main sequence
  initial begin
    logic [31:0] rd;
    logic [7:0] unmapped [4];
    unmapped = '{8'h30, 8'h48, 8'h00, 8'hfc};
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    void'($urandom(32'h2c2501bc));
    fuse_bits = $urandom();
    start_up();
    // all ones then all zeros: adjustable codes and reserved bits
    for (int i = 0; i < 5; i++) wr_reg(i, 32'hffff_ffff, 4'hf);
    chk_outs();
    read_all();
    for (int i = 0; i < 5; i++) wr_reg(i, 32'h0, 4'hf);
    chk_outs();
    // random traffic, byte lane 0 sometimes off
    for (int k = 0; k < 60; k++) begin
      wr_reg(int'($urandom_range(4)), $urandom(), 4'($urandom()));
      chk_outs();
    end
    read_all();
    // unmapped words: writes ignored, reads zero
    for (int k = 0; k < 4; k++) begin
      bus_cycle(1'b1, unmapped[k], 32'hffff_ffff, 4'hf, rd);
      bus_cycle(1'b0, unmapped[k], 32'h0, 4'h0, rd);
      chk_rd(rd, 32'h0);
    end
    read_all();
    chk_outs();
    // second reset with a new fuse image
    @(posedge mclk);
    rst_n <= 1'b0;
    fuse_bits <= $urandom();
    start_up();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
